// ### rtl/clk_src_div_pkg.sv
// constants, register map and types of the gpu clock source and divider control
// assumes a 100 mhz apb clock and one aligned 32-bit word per register
`default_nettype none
package clk_src_div_pkg;
    // clock of the register logic
    localparam int unsigned CLK_PERIOD_NS   = 10;
    // time the output is held off while a new source or divider is put in place
    localparam int unsigned SWITCH_SETTLE_NS = 40;
    localparam int unsigned SWITCH_SETTLE_CYC_I =
        (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SWITCH_SETTLE_CYC =
        (SWITCH_SETTLE_CYC_I < 1) ? 3'h1 : SWITCH_SETTLE_CYC_I[2:0];

    // number of controlled clocks: index 0 system clock, 1 core group clock
    localparam int unsigned NUM_CLK  = 2;
    localparam int unsigned CLK_SYS  = 0;
    localparam int unsigned CLK_CORE = 1;

    // byte offsets of the registers
    localparam logic [11:0] OFS_SYS_CTRL  = 12'h810;
    localparam logic [11:0] OFS_SYS_DIV   = 12'h814;
    localparam logic [11:0] OFS_CORE_CTRL = 12'h820;
    localparam logic [11:0] OFS_CORE_DIV  = 12'h824;
    localparam logic [11:0] OFS_CAP       = 12'hfbc;

    // control register fields
    localparam int unsigned SEL_LSB     = 0;
    localparam int unsigned SEL_MSB     = 7;
    localparam int unsigned SEL_ACK_LSB = 8;
    localparam int unsigned SEL_ACK_MSB = 15;
    localparam int unsigned DLY_LSB     = 24;
    localparam int unsigned DLY_MSB     = 31;
    // divider register fields
    localparam int unsigned DIV_LSB     = 0;
    localparam int unsigned DIV_MSB     = 4;
    localparam int unsigned DIV_ACK_LSB = 16;
    localparam int unsigned DIV_ACK_MSB = 20;
    // capability bit that says the gate entry delay field exists
    localparam int unsigned CAP_DLY_BIT = 0;

    // source select codes, one-hot, zero gates the clock
    localparam logic [7:0] SEL_GATED     = 8'h00;
    localparam logic [7:0] SEL_REFERENCE = 8'h01;
    localparam logic [7:0] SEL_SYS_PLL   = 8'h02;
    localparam logic [7:0] SEL_GPU_PLL   = 8'h04;

    // reset values
    localparam logic [7:0]  SEL_RESET  = SEL_REFERENCE;
    localparam logic [4:0]  DIV_RESET  = 5'h1f;
    localparam logic [7:0]  DLY_RESET  = 8'h00;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
    localparam logic [2:0]  SRC_NONE   = 3'h0;
    localparam logic [2:0]  SETTLE_ONE = 3'h1;
    localparam logic [4:0]  DIV_ONE    = 5'h01;
    localparam logic [7:0]  DLY_ONE    = 8'h01;

    // decoded register selected by an apb address
    typedef enum logic [2:0] {
        REG_NONE,
        REG_SYS_CTRL,
        REG_SYS_DIV,
        REG_CORE_CTRL,
        REG_CORE_DIV,
        REG_CAP
    } reg_sel_type;

    // source switch sequence of one clock
    typedef enum logic [1:0] {
        SW_RUN,
        SW_DRAIN
    } sw_state_type;
endpackage
`default_nettype wire

// ### rtl/gate_delay_if.sv
// link between the register logic and one gate entry delay unit
// assumes both ends run on pclk
`default_nettype none
interface gate_delay_if;
    logic [7:0] delay;    // gate entry delay in cycles
    logic       enable;   // delay field exists
    logic       gate_req; // request to gate the clock dynamically
    modport ctrl (output delay, output enable, input gate_req);
    modport unit (input delay, input enable, output gate_req);
endinterface
`default_nettype wire

// ### rtl/gate_entry_delay.sv
// gate entry delay unit: counts cycles after a clock stops being required
// assumes clk_required comes from another domain and is synchronised here
`default_nettype none
module gate_entry_delay
    import clk_src_div_pkg::*;
(
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // demand for the clock from the gpu
    input  wire logic  clk_required,
    // settings and request
    gate_delay_if.unit gd
);
    // whole state of the unit
    typedef struct packed {
        logic       sync1;  // first synchroniser stage
        logic       sync2;  // second synchroniser stage
        logic [7:0] cnt;    // idle cycles seen so far
        logic       gate;   // registered gate request
    } state_type;

    state_type s_q;
    state_type s_d;

    // next state: count idle cycles, then raise the request
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = clk_required;
        s_d.sync2 = s_q.sync1;
        if (s_q.sync2) begin
            // clock wanted again: drop request and restart the count
            s_d.cnt  = DLY_RESET;
            s_d.gate = 1'b0;
        end else if (!s_q.gate) begin
            // field absent behaves as zero delay
            if (!gd.enable || s_q.cnt == gd.delay) begin
                s_d.gate = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + DLY_ONE;
            end
        end
    end

    // state register; the synchroniser resets to "required" so that no
    // gate request is raised just because reset was released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{sync1: 1'b1, sync2: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign gd.gate_req = s_q.gate;
endmodule
`default_nettype wire

// ### rtl/clk_src_div_ctrl.sv
// gpu clock source select, divider and gate entry delay control, apb slave
// assumes apb on pclk; clock-required pins come from the gpu domain
// Function
// - select codes one-hot: reference, system, gpu pll
// - select zero gates the clock off
// - bits 15:8 report source in effect
// - wait delay field cycles before gate request
// - delay field exists only when capability set
// - divide by divider request plus one
// - bits 20:16 report divider in effect
// - divider applies to the selected source
// - system control, divider, core control always present
// - independent source select for both clocks
// - core clock has its own divider register
`default_nettype none
module clk_src_div_ctrl
    import clk_src_div_pkg::*;
#(
    // capability: gate entry delay field implemented
    parameter logic GATE_DELAY_CAP = 1'b1
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // gpu system clock
    input  wire logic        sys_clk_required,
    output logic      [2:0]  sys_clk_source_en,
    output logic             sys_clk_tick,
    output logic             sys_clk_gate_req,
    // gpu core group clock
    input  wire logic        core_clk_required,
    output logic      [2:0]  core_clk_source_en,
    output logic             core_clk_tick,
    output logic             core_clk_gate_req
);
    // whole state of the register logic and both clock channels
    typedef struct packed {
        logic         [NUM_CLK-1:0][7:0] sel;      // requested source
        logic         [NUM_CLK-1:0][7:0] dly;      // gate entry delay
        logic         [NUM_CLK-1:0][4:0] div;      // requested divider
        logic         [NUM_CLK-1:0][7:0] sel_ack;  // source in effect
        logic         [NUM_CLK-1:0][4:0] div_ack;  // divider in effect
        sw_state_type [NUM_CLK-1:0]      sw;       // switch sequence
        logic         [NUM_CLK-1:0][2:0] settle;   // drain cycles seen
        logic         [NUM_CLK-1:0][4:0] div_cnt;  // divider counter
        logic         [NUM_CLK-1:0]      tick;     // divided clock enable
        logic         [NUM_CLK-1:0][2:0] src_en;   // routed source, one-hot
        logic                     [31:0] rdata;    // read data
        logic                            ready;    // access phase answer
    } state_type;

    state_type s_q;
    state_type s_d;

    // links to the two gate entry delay units
    gate_delay_if gd_sys ();
    gate_delay_if gd_core ();

    // map an apb address onto a register
    function automatic reg_sel_type reg_decode(input logic [11:0] addr);
        logic [11:0] word;
        word = {addr[11:2], 2'b00};
        unique case (word)
            OFS_SYS_CTRL:  reg_decode = REG_SYS_CTRL;
            OFS_SYS_DIV:   reg_decode = REG_SYS_DIV;
            OFS_CORE_CTRL: reg_decode = REG_CORE_CTRL;
            OFS_CORE_DIV:  reg_decode = REG_CORE_DIV;
            OFS_CAP:       reg_decode = REG_CAP;
            default:       reg_decode = REG_NONE;
        endcase
    endfunction

    // one-hot source enables for a select code; anything else routes nothing
    function automatic logic [2:0] src_decode(input logic [7:0] sel);
        unique case (sel)
            SEL_REFERENCE: src_decode = 3'h1;
            SEL_SYS_PLL:   src_decode = 3'h2;
            SEL_GPU_PLL:   src_decode = 3'h4;
            SEL_GATED:     src_decode = SRC_NONE;
            // reserved codes are undefined; keep the clock off
            default:       src_decode = SRC_NONE;
        endcase
    endfunction

    // read value of a control register
    function automatic logic [31:0] ctrl_word(input logic [7:0] dly,
                                               input logic [7:0] ack,
                                               input logic [7:0] sel);
        logic [31:0] w;
        w = WORD_ZERO;
        if (GATE_DELAY_CAP) begin
            w[DLY_MSB:DLY_LSB] = dly;
        end
        w[SEL_ACK_MSB:SEL_ACK_LSB] = ack;
        w[SEL_MSB:SEL_LSB]         = sel;
        ctrl_word = w;
    endfunction

    // read value of a divider register
    function automatic logic [31:0] div_word(input logic [4:0] ack,
                                              input logic [4:0] div);
        logic [31:0] w;
        w = WORD_ZERO;
        w[DIV_ACK_MSB:DIV_ACK_LSB] = ack;
        w[DIV_MSB:DIV_LSB]         = div;
        div_word = w;
    endfunction

    // next state: apb access, then the switch and divider of each clock
    always_comb begin
        reg_sel_type rsel;
        logic        wr_en;
        logic [31:0] cap;
        s_d   = s_q;
        rsel  = reg_decode(paddr);
        cap   = WORD_ZERO;
        cap[CAP_DLY_BIT] = GATE_DELAY_CAP;
        // a write takes effect at the edge where the master sees pready
        wr_en = psel && penable && pwrite && s_q.ready;

        // one wait state: answer in the cycle after the first access cycle
        s_d.ready = psel && penable && !s_q.ready;

        // load read data with the answer
        if (psel && penable && !s_q.ready) begin
            unique case (rsel)
                REG_SYS_CTRL:  s_d.rdata = ctrl_word(s_q.dly[CLK_SYS],
                                                     s_q.sel_ack[CLK_SYS],
                                                     s_q.sel[CLK_SYS]);
                REG_SYS_DIV:   s_d.rdata = div_word(s_q.div_ack[CLK_SYS],
                                                    s_q.div[CLK_SYS]);
                REG_CORE_CTRL: s_d.rdata = ctrl_word(s_q.dly[CLK_CORE],
                                                     s_q.sel_ack[CLK_CORE],
                                                     s_q.sel[CLK_CORE]);
                REG_CORE_DIV:  s_d.rdata = div_word(s_q.div_ack[CLK_CORE],
                                                    s_q.div[CLK_CORE]);
                REG_CAP:       s_d.rdata = cap;
                // unmapped space reads as zero
                REG_NONE:      s_d.rdata = WORD_ZERO;
            endcase
        end

        // register writes; unmapped and read-only space ignores them
        if (wr_en) begin
            unique case (rsel)
                REG_SYS_CTRL: begin
                    s_d.sel[CLK_SYS] = pwdata[SEL_MSB:SEL_LSB];
                    if (GATE_DELAY_CAP) begin
                        s_d.dly[CLK_SYS] = pwdata[DLY_MSB:DLY_LSB];
                    end
                end
                REG_SYS_DIV: begin
                    s_d.div[CLK_SYS] = pwdata[DIV_MSB:DIV_LSB];
                end
                REG_CORE_CTRL: begin
                    s_d.sel[CLK_CORE] = pwdata[SEL_MSB:SEL_LSB];
                    if (GATE_DELAY_CAP) begin
                        s_d.dly[CLK_CORE] = pwdata[DLY_MSB:DLY_LSB];
                    end
                end
                REG_CORE_DIV: begin
                    s_d.div[CLK_CORE] = pwdata[DIV_MSB:DIV_LSB];
                end
                REG_CAP, REG_NONE: begin
                    // writes ignored
                end
            endcase
        end

        // each clock switches on its own
        for (int i = 0; i < NUM_CLK; i++) begin
            s_d.tick[i] = 1'b0;
            unique case (s_q.sw[i])
                SW_RUN: begin
                    if (s_q.sel[i] != s_q.sel_ack[i] || s_q.div[i] != s_q.div_ack[i]) begin
                        // stop the output before touching source or divider
                        s_d.sw[i]      = SW_DRAIN;
                        s_d.src_en[i]  = SRC_NONE;
                        s_d.settle[i]  = SETTLE_ONE;
                    end else if (s_q.src_en[i] != SRC_NONE) begin
                        // divide by the value in effect plus one
                        if (s_q.div_cnt[i] == s_q.div_ack[i]) begin
                            s_d.div_cnt[i] = 5'h00;
                            s_d.tick[i]    = 1'b1;
                        end else begin
                            s_d.div_cnt[i] = s_q.div_cnt[i] + DIV_ONE;
                        end
                    end
                end
                SW_DRAIN: begin
                    if (s_q.settle[i] == SWITCH_SETTLE_CYC) begin
                        // new setting takes effect; acknowledge it now
                        s_d.sw[i]      = SW_RUN;
                        s_d.sel_ack[i] = s_q.sel[i];
                        s_d.div_ack[i] = s_q.div[i];
                        // divider follows whichever source is selected
                        s_d.src_en[i]  = src_decode(s_q.sel[i]);
                        s_d.div_cnt[i] = 5'h00;
                    end else begin
                        s_d.settle[i] = s_q.settle[i] + SETTLE_ONE;
                    end
                end
            endcase
        end
    end

    // state register; reset runs both clocks from the reference, divide 32
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CLK; i++) begin
                s_q.sel[i]     <= SEL_RESET;
                s_q.sel_ack[i] <= SEL_RESET;
                s_q.div[i]     <= DIV_RESET;
                s_q.div_ack[i] <= DIV_RESET;
                s_q.dly[i]     <= DLY_RESET;
                s_q.sw[i]      <= SW_RUN;
                s_q.settle[i]  <= SRC_NONE;
                s_q.div_cnt[i] <= 5'h00;
                s_q.tick[i]    <= 1'b0;
                s_q.src_en[i]  <= 3'h1;
            end
            s_q.rdata <= WORD_ZERO;
            s_q.ready <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // settings towards the gate entry delay units
    assign gd_sys.delay   = s_q.dly[CLK_SYS];
    assign gd_sys.enable  = GATE_DELAY_CAP;
    assign gd_core.delay  = s_q.dly[CLK_CORE];
    assign gd_core.enable = GATE_DELAY_CAP;

    // gate entry delay of the system clock
    gate_entry_delay u_sys_gate (
        .pclk         (pclk),
        .presetn      (presetn),
        .clk_required (sys_clk_required),
        .gd           (gd_sys.unit)
    );

    // gate entry delay of the core group clock
    gate_entry_delay u_core_gate (
        .pclk         (pclk),
        .presetn      (presetn),
        .clk_required (core_clk_required),
        .gd           (gd_core.unit)
    );

    // outputs straight from flip-flops, except pslverr which is tied low
    assign prdata             = s_q.rdata;
    assign pready             = s_q.ready;
    assign pslverr            = 1'b0;
    assign sys_clk_source_en  = s_q.src_en[CLK_SYS];
    assign sys_clk_tick       = s_q.tick[CLK_SYS];
    assign sys_clk_gate_req   = gd_sys.gate_req;
    assign core_clk_source_en = s_q.src_en[CLK_CORE];
    assign core_clk_tick      = s_q.tick[CLK_CORE];
    assign core_clk_gate_req  = gd_core.gate_req;
endmodule
`default_nettype wire

// ### dv/clk_src_div_props.sv
// checker for the gpu clock source and divider control block
// assumes it is bound to clk_src_div_ctrl and sees only that module's ports
`default_nettype none
module clk_src_div_props #(
    parameter logic GATE_DELAY_CAP = 1'b1
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // gpu system clock
    input wire logic        sys_clk_required,
    input wire logic [2:0]  sys_clk_source_en,
    input wire logic        sys_clk_tick,
    input wire logic        sys_clk_gate_req,
    // gpu core group clock
    input wire logic        core_clk_required,
    input wire logic [2:0]  core_clk_source_en,
    input wire logic        core_clk_tick,
    input wire logic        core_clk_gate_req
);
    // one clock domain, reset disables every check
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a routed source is dropped: start of a switch
    sequence sys_drain;
        sys_clk_source_en != 3'h0 ##1 sys_clk_source_en == 3'h0;
    endsequence
    // apb access phase still waiting for its answer
    sequence access_wait;
        psel && penable && !pready;
    endsequence

    onehot_source_a: assert property (
        $onehot0(sys_clk_source_en) && $onehot0(core_clk_source_en))
        else $error("source enable not one-hot");
    sys_gated_tick_a: assert property (
        sys_clk_source_en == 3'h0 ##1 sys_clk_source_en == 3'h0 |-> !sys_clk_tick)
        else $error("system tick while gated");
    core_gated_tick_a: assert property (
        core_clk_source_en == 3'h0 ##1 core_clk_source_en == 3'h0 |-> !core_clk_tick)
        else $error("core tick while gated");
    gate_wait_a: assert property (
        $rose(sys_clk_gate_req) |-> !$past(sys_clk_required) && !$past(sys_clk_required, 2))
        else $error("gate request without idle time");
    gate_drop_a: assert property (
        $rose(sys_clk_required) |-> ##[1:5] !sys_clk_gate_req)
        else $error("gate request kept after demand");
    gate_hold_a: assert property (
        core_clk_required [*5] |-> !core_clk_gate_req)
        else $error("core gate request while required");
    drain_hold_a: assert property (
        sys_drain |-> ##1 (sys_clk_source_en == 3'h0) [*3])
        else $error("switch drain too short");
    ready_pulse_a: assert property (
        access_wait |=> pready && !pslverr)
        else $error("apb answer late or in error");
endmodule

// attach the checker to every instance of the control block
bind clk_src_div_ctrl clk_src_div_props #(.GATE_DELAY_CAP(GATE_DELAY_CAP)) clk_src_div_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_clk_required(sys_clk_required), .sys_clk_source_en(sys_clk_source_en),
    .sys_clk_tick(sys_clk_tick), .sys_clk_gate_req(sys_clk_gate_req),
    .core_clk_required(core_clk_required), .core_clk_source_en(core_clk_source_en),
    .core_clk_tick(core_clk_tick), .core_clk_gate_req(core_clk_gate_req));
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the gpu clock source and divider control block
// assumes a 100 mhz pclk and the apb answer timing of the control block
`default_nettype none
module tb
    import clk_src_div_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk              = 1'b0;  // apb clock
    logic        presetn           = 1'b0;  // reset, active low
    logic        psel              = 1'b0;  // apb request
    logic        penable           = 1'b0;
    logic        pwrite            = 1'b0;
    logic [11:0] paddr             = 12'h000;
    logic [31:0] pwdata            = WORD_ZERO;
    logic        sys_clk_required  = 1'b1;  // clocks wanted at start
    logic        core_clk_required = 1'b1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  sys_clk_source_en;
    logic [2:0]  core_clk_source_en;
    logic        sys_clk_tick;
    logic        core_clk_tick;
    logic        sys_clk_gate_req;
    logic        core_clk_gate_req;
    logic [31:0] rd;                        // last read word
    int          n;                         // measured cycle count
    int          bad_count         = 0;
    int          compares          = 0;
    int          cycles            = 0;
    // reset map: address and expected word, last entry unmapped
    logic [11:0] reg_addr [6] = '{OFS_SYS_CTRL, OFS_SYS_DIV, OFS_CORE_CTRL, OFS_CORE_DIV,
                                  OFS_CAP, 12'h818};
    logic [31:0] reg_rst  [6] = '{32'h0000_0101, 32'h001f_001f, 32'h0000_0101,
                                  32'h001f_001f, 32'h0000_0001, WORD_ZERO};
    // select codes and the routing each one gives
    logic [7:0]  codes    [4] = '{SEL_SYS_PLL, SEL_GPU_PLL, SEL_GATED, SEL_REFERENCE};
    logic [2:0]  routes   [4] = '{3'h2, 3'h4, 3'h0, 3'h1};
    // gate entry delays tried, and which clock takes them
    logic [7:0]  delays   [3] = '{8'h00, 8'h05, 8'hff};
    logic        on_sys   [3] = '{1'b1, 1'b1, 1'b0};

    // compare and count
    `define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
        $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end

    clk_src_div_ctrl #(.GATE_DELAY_CAP(1'b1)) clk_src_div_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_clk_required(sys_clk_required), .sys_clk_source_en(sys_clk_source_en),
        .sys_clk_tick(sys_clk_tick), .sys_clk_gate_req(sys_clk_gate_req),
        .core_clk_required(core_clk_required), .core_clk_source_en(core_clk_source_en),
        .core_clk_tick(core_clk_tick), .core_clk_gate_req(core_clk_gate_req));

    // clock generator
    initial begin
        forever #5 pclk = ~pclk;
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // read until the masked word matches or the tries run out
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, a, WORD_ZERO, rd);
            if ((rd & m) === e) break;
        end
    endtask

    // cycles between two ticks of one clock
    task automatic period(input logic sys, output int p);
        p = 0;
        do @(posedge pclk); while ((sys ? sys_clk_tick : core_clk_tick) !== 1'b1);
        do begin @(posedge pclk); p++; end while ((sys ? sys_clk_tick : core_clk_tick) !== 1'b1);
    endtask

    // drop demand, count cycles to gate request, then restore demand
    task automatic gate_time(input logic sys, output int p);
        @(posedge pclk);
        if (sys) sys_clk_required <= 1'b0;
        else core_clk_required <= 1'b0;
        p = 0;
        do begin @(posedge pclk); #1; p++; end
        while ((sys ? sys_clk_gate_req : core_clk_gate_req) !== 1'b1 && p < 400);
        @(posedge pclk);
        sys_clk_required  <= 1'b1;
        core_clk_required <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1 `CHK(sys_clk_source_en, 3'h1)
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, reg_addr[i], WORD_ZERO, rd);
            `CHK(rd, reg_rst[i])
        end
        period(1'b1, n);
        `CHK(n, 32)
        // unmapped write is dropped
        apb(1'b1, 12'h818, 32'hffff_ffff, rd);
        apb(1'b0, 12'h818, WORD_ZERO, rd);
        `CHK(rd, WORD_ZERO)
        // divide by one, acknowledge bits written are ignored
        apb(1'b1, OFS_SYS_DIV, 32'h001f_0000, rd);
        poll(OFS_SYS_DIV, 32'hffff_ffff, WORD_ZERO);
        `CHK(rd, WORD_ZERO)
        period(1'b1, n);
        `CHK(n, 1)
        // every select code on the system clock
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_SYS_CTRL, {24'h0, codes[i]}, rd);
            apb(1'b0, OFS_SYS_CTRL, WORD_ZERO, rd);
            `CHK(rd[15:8], codes[(i + 3) % 4])
            `CHK(sys_clk_source_en, 3'h0)
            poll(OFS_SYS_CTRL, 32'h0000_ff00, {16'h0, codes[i], 8'h0});
            `CHK(rd[15:8], codes[i])
            #1 `CHK(sys_clk_source_en, routes[i])
            `CHK(core_clk_source_en, 3'h1)
        end
        // divider on the system pll source, then on the core clock from the reference
        apb(1'b1, OFS_SYS_CTRL, 32'h0000_0002, rd);
        apb(1'b1, OFS_SYS_DIV, 32'h0000_0004, rd);
        poll(OFS_SYS_DIV, 32'hffff_ffff, 32'h0004_0004);
        `CHK(rd, 32'h0004_0004)
        period(1'b1, n);
        `CHK(n, 5)
        apb(1'b1, OFS_CORE_DIV, 32'h0000_0002, rd);
        poll(OFS_CORE_DIV, 32'hffff_ffff, 32'h0002_0002);
        `CHK(rd, 32'h0002_0002)
        period(1'b0, n);
        `CHK(n, 3)
        // gate entry delay at both ends of its range
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, on_sys[i] ? OFS_SYS_CTRL : OFS_CORE_CTRL,
                {delays[i], 16'h0, on_sys[i] ? SEL_SYS_PLL : SEL_REFERENCE}, rd);
            apb(1'b0, on_sys[i] ? OFS_SYS_CTRL : OFS_CORE_CTRL, WORD_ZERO, rd);
            `CHK(rd[31:24], delays[i])
            gate_time(on_sys[i], n);
            `CHK(n, 3 + int'(delays[i]))
        end
        end_of_test();
    end
endmodule
`default_nettype wire
